// file: bridge_regs.svh
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH

// Instruction register width and codes
`define IR_WIDTH               4
`define IR_RESET_CODE          4'h1
`define IR_BYPASS_CODE         4'hF
`define IR_BRIDGE_CODE         4'h2
`define IR_RECONFIG_CODE       4'h3

// Clock rate and restart pulse timing
`define CLK_FREQ_MHZ           40
`define RECONFIG_PULSE_NS      500
`define RECONFIG_PULSE_CYCLES  ((`RECONFIG_PULSE_NS*`CLK_FREQ_MHZ+999)/1000)
`define PULSE_CNT_WIDTH        6

`endif

// file: bridge_pkg.sv
package bridge_pkg;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE,
      SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
      UPDATE_DR,
      SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
      UPDATE_IR
   } tap_state_t;

   typedef struct packed {
      logic clk;
      logic select_low;
      logic cmd;
   } mem_pins_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtag_pins_t;

endpackage : bridge_pkg

// file: jtag_flash_bridge.sv
`timescale 1ns/10ps
`include "bridge_regs.svh"

module jtag_flash_bridge
   import bridge_pkg::*;
#(
   parameter bit HAS_USER_CLOCK = 1'b0
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // JTAG pins
   input  wire jtag_pins_t jtag_i,
   output logic            tdo_o,
   output logic            tdo_oe_o,
   // Serial memory pins
   output mem_pins_t       mem_o,
   input  wire logic       memory_serial_in_i,
   input  wire logic       user_clock_input_i,
   input  wire logic       user_clock_select_i,
   // Configuration control
   input  wire logic       configuration_complete_i,
   input  wire logic       active_serial_busy_i,
   output logic            active_serial_abort_o,
   output logic            reconfig_pulse_o,
   output logic            user_mode_o
);

   jtag_pins_t                  jtag_s1_reg;
   jtag_pins_t                  jtag_s2_reg;
   logic                        tck_last_reg;
   logic                        min_s1_reg;
   logic                        min_s2_reg;
   logic                        uclk_s1_reg;
   logic                        uclk_s2_reg;
   logic                        busy_s1_reg;
   logic                        busy_s2_reg;
   tap_state_t                  tap_reg;
   tap_state_t                  tap_next;
   logic [`IR_WIDTH-1:0]        ir_shift_reg;
   logic [`IR_WIDTH-1:0]        ir_reg;
   logic                        bypass_reg;
   logic                        mem_bit_reg;
   logic [`PULSE_CNT_WIDTH-1:0] pulse_cnt_reg;
   logic                        tck_rise;
   logic                        tck_fall;
   logic                        bridge_sel;
   logic                        xfer_active;
   logic                        clk_src;

   // Two-flop synchronisers on JTAG, memory data, user clock and busy inputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         jtag_s1_reg  <= '0;
         jtag_s2_reg  <= '0;
         tck_last_reg <= 1'b0;
         min_s1_reg   <= 1'b0;
         min_s2_reg   <= 1'b0;
         uclk_s1_reg  <= 1'b0;
         uclk_s2_reg  <= 1'b0;
         busy_s1_reg  <= 1'b0;
         busy_s2_reg  <= 1'b0;
      end
      else
      begin
         jtag_s1_reg  <= jtag_i;
         jtag_s2_reg  <= jtag_s1_reg;
         tck_last_reg <= jtag_s2_reg.tck;
         min_s1_reg   <= memory_serial_in_i;
         min_s2_reg   <= min_s1_reg;
         uclk_s1_reg  <= user_clock_input_i;
         uclk_s2_reg  <= uclk_s1_reg;
         busy_s1_reg  <= active_serial_busy_i;
         busy_s2_reg  <= busy_s1_reg;
      end
   end

   assign tck_rise   = jtag_s2_reg.tck & ~tck_last_reg;
   assign tck_fall   = ~jtag_s2_reg.tck & tck_last_reg;
   assign bridge_sel = (ir_reg == `IR_BRIDGE_CODE);

   // Transaction spans capture through exit of the data path
   assign xfer_active = bridge_sel &&
      (tap_reg inside {CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR});

   // Memory clock source; user clock only on the transceiver variant
   assign clk_src = (HAS_USER_CLOCK && user_clock_select_i) ? uclk_s2_reg
                                                           : jtag_s2_reg.tck;

   always_comb
   begin
      tap_next = tap_reg;
      case (tap_reg)
         TEST_LOGIC_RESET: tap_next = jtag_s2_reg.tms ? TEST_LOGIC_RESET
                                                      : RUN_IDLE;
         RUN_IDLE:   tap_next = jtag_s2_reg.tms ? SELECT_DR  : RUN_IDLE;
         SELECT_DR:  tap_next = jtag_s2_reg.tms ? SELECT_IR  : CAPTURE_DR;
         CAPTURE_DR: tap_next = jtag_s2_reg.tms ? EXIT1_DR   : SHIFT_DR;
         SHIFT_DR:   tap_next = jtag_s2_reg.tms ? EXIT1_DR   : SHIFT_DR;
         EXIT1_DR:   tap_next = jtag_s2_reg.tms ? UPDATE_DR  : PAUSE_DR;
         PAUSE_DR:   tap_next = jtag_s2_reg.tms ? EXIT2_DR   : PAUSE_DR;
         EXIT2_DR:   tap_next = jtag_s2_reg.tms ? UPDATE_DR  : SHIFT_DR;
         UPDATE_DR:  tap_next = jtag_s2_reg.tms ? SELECT_DR  : RUN_IDLE;
         SELECT_IR:  tap_next = jtag_s2_reg.tms ? TEST_LOGIC_RESET
                                                : CAPTURE_IR;
         CAPTURE_IR: tap_next = jtag_s2_reg.tms ? EXIT1_IR   : SHIFT_IR;
         SHIFT_IR:   tap_next = jtag_s2_reg.tms ? EXIT1_IR   : SHIFT_IR;
         EXIT1_IR:   tap_next = jtag_s2_reg.tms ? UPDATE_IR  : PAUSE_IR;
         PAUSE_IR:   tap_next = jtag_s2_reg.tms ? EXIT2_IR   : PAUSE_IR;
         EXIT2_IR:   tap_next = jtag_s2_reg.tms ? UPDATE_IR  : SHIFT_IR;
         UPDATE_IR:  tap_next = jtag_s2_reg.tms ? SELECT_DR  : RUN_IDLE;
         default:    tap_next = TEST_LOGIC_RESET;
      endcase
   end

   // TAP controller and instruction register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tap_reg      <= TEST_LOGIC_RESET;
         ir_shift_reg <= `IR_RESET_CODE;
         ir_reg       <= `IR_RESET_CODE;
         bypass_reg   <= 1'b0;
      end
      else if (tck_rise)
      begin
         tap_reg <= tap_next;
         case (tap_reg)
            TEST_LOGIC_RESET: ir_reg <= `IR_RESET_CODE;
            CAPTURE_IR: ir_shift_reg <= `IR_RESET_CODE;
            SHIFT_IR:   ir_shift_reg <= {jtag_s2_reg.tdi,
                                         ir_shift_reg[`IR_WIDTH-1:1]};
            UPDATE_IR:  ir_reg <= ir_shift_reg;
            CAPTURE_DR: bypass_reg <= 1'b0;
            SHIFT_DR:   bypass_reg <= jtag_s2_reg.tdi;
            default:    bypass_reg <= bypass_reg;
         endcase
      end
   end

   // Memory pins follow JTAG; clock waits for first fall in shift
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_o       <= '{clk: 1'b0, select_low: 1'b1, cmd: 1'b0};
         mem_bit_reg <= 1'b0;
      end
      else
      begin
         mem_o.select_low <= ~xfer_active;
         mem_o.clk <= (bridge_sel && tap_reg == SHIFT_DR && tdo_oe_o)
                      ? clk_src : 1'b0;
         if (tck_fall && bridge_sel && tap_reg == SHIFT_DR)
            mem_o.cmd <= jtag_s2_reg.tdi;
         if (tck_rise && bridge_sel && tap_reg == SHIFT_DR)
            mem_bit_reg <= min_s2_reg;
      end
   end

   // Test data out changes on the falling test clock edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_oe_o <= (tap_reg == SHIFT_DR) || (tap_reg == SHIFT_IR);
         if (tap_reg == SHIFT_IR)
            tdo_o <= ir_shift_reg[0];
         else if (bridge_sel)
            tdo_o <= mem_bit_reg;
         else
            tdo_o <= bypass_reg;
      end
   end

   // Restart pulse only on the host's instruction, never on its own
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pulse_cnt_reg    <= '0;
         reconfig_pulse_o <= 1'b0;
      end
      else if (tck_rise && tap_reg == UPDATE_IR &&
               ir_shift_reg == `IR_RECONFIG_CODE)
      begin
         pulse_cnt_reg    <= `PULSE_CNT_WIDTH'(`RECONFIG_PULSE_CYCLES);
         reconfig_pulse_o <= 1'b1;
      end
      else if (pulse_cnt_reg != '0)
      begin
         pulse_cnt_reg    <= pulse_cnt_reg - 1'b1;
         reconfig_pulse_o <= (pulse_cnt_reg != `PULSE_CNT_WIDTH'(1));
      end
   end

   // User mode regardless of done line; JTAG wins over active serial
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         user_mode_o           <= 1'b0;
         active_serial_abort_o <= 1'b0;
      end
      else
      begin
         user_mode_o <= 1'b1 | configuration_complete_i;
         active_serial_abort_o <= busy_s2_reg &&
                                  (tap_reg != TEST_LOGIC_RESET);
      end
   end

   sequence s_bridge_shift_fall;
      tck_fall && bridge_sel && tap_reg == SHIFT_DR;
   endsequence

   property p_select_idle;
      @(posedge clk_i) disable iff (rst_i)
      !xfer_active |=> mem_o.select_low;
   endproperty
   a_select_idle: assert property (p_select_idle)
      else $error("select low outside a transaction");

   property p_clock_idle;
      @(posedge clk_i) disable iff (rst_i)
      !(bridge_sel && tap_reg == SHIFT_DR && tdo_oe_o) |=> !mem_o.clk;
   endproperty
   a_clock_idle: assert property (p_clock_idle)
      else $error("memory clock toggling while idle");

   property p_clock_follows;
      @(posedge clk_i) disable iff (rst_i)
      (bridge_sel && tap_reg == SHIFT_DR && tdo_oe_o && clk_src) |=> mem_o.clk;
   endproperty
   a_clock_follows: assert property (p_clock_follows)
      else $error("memory clock not following source");

   property p_forward;
      @(posedge clk_i) disable iff (rst_i)
      s_bridge_shift_fall |=> mem_o.cmd == $past(jtag_s2_reg.tdi);
   endproperty
   a_forward: assert property (p_forward)
      else $error("shifted bit not forwarded to memory");

   property p_user_mode;
      @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> user_mode_o;
   endproperty
   a_user_mode: assert property (p_user_mode)
      else $error("user mode not reached");

   property p_abort;
      @(posedge clk_i) disable iff (rst_i)
      (busy_s2_reg && tap_reg != TEST_LOGIC_RESET) |=> active_serial_abort_o;
   endproperty
   a_abort: assert property (p_abort)
      else $error("active serial not aborted");

   property p_no_self_restart;
      @(posedge clk_i) disable iff (rst_i)
      $rose(reconfig_pulse_o) |-> $past(tck_rise && tap_reg == UPDATE_IR &&
                                        ir_shift_reg == `IR_RECONFIG_CODE);
   endproperty
   a_no_self_restart: assert property (p_no_self_restart)
      else $error("restart without host instruction");

   property p_pulse_width;
      @(posedge clk_i) disable iff (rst_i)
      $rose(reconfig_pulse_o) |-> reconfig_pulse_o [*8];
   endproperty
   a_pulse_width: assert property (p_pulse_width)
      else $error("restart pulse too short");

endmodule : jtag_flash_bridge

// file: mem_model.sv
`timescale 1ns/10ps
module mem_model
   import bridge_pkg::*;
#(
   parameter logic [15:0] PATTERN = 16'h3C96
)
(
   // Pins from the bridge
   input  wire mem_pins_t mem_i,
   // Data back to the bridge
   output logic           data_o
);
   logic [31:0] rx_bits = '0;
   int          n_rise  = 0;

   initial
      data_o = 1'h0;

   // Capture data into memory on each of the first 32 rising clocks while selected
   always @(posedge mem_i.clk)
   begin
      if (mem_i.select_low === 1'h0 && n_rise < 32)
      begin
         rx_bits[31 - n_rise] = mem_i.cmd;
         n_rise++;
      end
   end

   // Next output bit after each falling clock
   always @(negedge mem_i.clk)
   begin
      if (mem_i.select_low === 1'h0)
         data_o = PATTERN[15 - (n_rise % 16)];
   end

   // Deselected: line no longer holds the last value
   always @(posedge mem_i.select_low)
      data_o = ~data_o;

   always @(negedge mem_i.select_low)
   begin
      n_rise = 0;
      rx_bits = '0;
      data_o = PATTERN[15];
   end
endmodule : mem_model

// file: jtag_flash_bridge_test.sv
`timescale 1ns/10ps
module jtag_flash_bridge_test;
   import bridge_pkg::*;
   localparam logic [15:0] WRITE_DATA = 16'hA5C3;
   localparam logic [15:0] READ_DATA  = 16'h3C96;

   logic       clk_i;
   logic       rst_i;
   logic       busy;
   logic       tdo;
   logic       tdo_oe;
   logic       abort;
   logic       pulse;
   logic       user_mode;
   logic       mem_data;
   jtag_pins_t jtag;
   mem_pins_t  mem;
   int         err_count  = 0;
   int         n_compared = 0;
   int         cycles     = 0;
   int         pulse_run  = 0;
   int         pulse_len  = 0;

   jtag_flash_bridge uut (
      .clk_i                    (clk_i),
      .rst_i                    (rst_i),
      .jtag_i                   (jtag),
      .tdo_o                    (tdo),
      .tdo_oe_o                 (tdo_oe),
      .mem_o                    (mem),
      .memory_serial_in_i       (mem_data),
      .user_clock_input_i       (1'h0),
      .user_clock_select_i      (1'h0),
      .configuration_complete_i (1'h0),
      .active_serial_busy_i     (busy),
      .active_serial_abort_o    (abort),
      .reconfig_pulse_o         (pulse),
      .user_mode_o              (user_mode)
   );

   mem_model #(.PATTERN(READ_DATA)) memory (
      .mem_i  (mem),
      .data_o (mem_data)
   );

   initial
   begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Restart pulse width and run limit
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (pulse === 1'h1)
         pulse_run <= pulse_run + 1;
      else if (pulse_run != 0)
      begin
         pulse_len <= pulse_run;
         pulse_run <= 0;
      end
      if (cycles == 5000)
      begin
         err_count++;
         finish_test();
      end
   end

   task automatic check_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_bit

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_word

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_clk

   // One test clock period of 200 ns, ending with the clock high
   task automatic tck_cycle(input logic tms, input logic tdi);
      jtag = '{tck: 1'h0, tms: tms, tdi: tdi};
      wait_clk(4);
      jtag.tck = 1'h1;
      wait_clk(4);
   endtask : tck_cycle

   task automatic tms_walk(input logic [7:0] seq, input int n);
      for (int i = 0; i < n; i++)
         tck_cycle(seq[i], 1'h0);
   endtask : tms_walk

   // From run-test-idle, load an instruction and return to idle
   task automatic shift_ir(input logic [3:0] code);
      tms_walk(8'h03, 4);
      for (int i = 0; i < 4; i++)
         tck_cycle(i == 3, code[i]);
      tms_walk(8'h01, 2);
   endtask : shift_ir

   task automatic test_reset;
      wait_clk(5);
      check_word({mem, user_mode, pulse, abort}, 16'h0010);
      rst_i = 1'h0;
      wait_clk(2);
      check_bit(user_mode, 1'h1);
   endtask : test_reset

   task automatic test_abort;
      busy = 1'h1;
      tms_walk(8'hFF, 5);
      wait_clk(4);
      check_bit(abort, 1'h0);
      tms_walk(8'h00, 1);
      wait_clk(4);
      check_bit(abort, 1'h1);
      busy = 1'h0;
      wait_clk(4);
      check_bit(abort, 1'h0);
   endtask : test_abort

   task automatic test_write;
      logic [15:0] rd;
      rd = '0;
      shift_ir(4'h2);
      tms_walk(8'h01, 3);
      check_bit(mem.select_low, 1'h0);
      for (int i = 0; i < 17; i++)
      begin
         tck_cycle(i == 16, i < 16 ? WRITE_DATA[15 - i] : 1'h0);
         if (i > 0)
            rd[16 - i] = tdo;
         if (i == 5)
            check_bit(tdo_oe, 1'h1);
      end
      tms_walk(8'h01, 2);
      wait_clk(2);
      check_word({13'h0000, mem.select_low, mem.clk, tdo_oe}, 16'h0004);
      check_word(memory.rx_bits[31:16], WRITE_DATA);
      check_word(rd, READ_DATA);
   endtask : test_write

   task automatic test_restart;
      check_word(pulse_len[15:0], 16'h0000);
      shift_ir(4'h3);
      wait_clk(30);
      check_word(pulse_len[15:0], 16'h0014);
   endtask : test_restart

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   initial
   begin
      rst_i = 1'h1;
      busy = 1'h0;
      jtag = '0;
      test_reset();
      test_abort();
      test_write();
      test_restart();
      finish_test();
   end
endmodule : jtag_flash_bridge_test
